// ==== prm_pkg.sv ====
// Shared constants and carrier types for the position range mapping block.
`default_nettype none
package prm_pkg;
    // ****************************************************************
    // Geometry of the measuring range, in rotations and base counts.
    // ****************************************************************
    localparam int ROT_CNT = 400;
    localparam int ENC_ROTS = 256;
    localparam int POS_ROTS = 250;
    localparam int MARGIN_ROTS = 3;
    localparam logic signed [31:0] ENC_RANGE = 32'(ROT_CNT * ENC_ROTS);
    localparam logic signed [31:0] MARGIN_CNT = 32'(ROT_CNT * MARGIN_ROTS);
    localparam logic signed [31:0] LOW_OFS = 32'(ROT_CNT * (POS_ROTS + MARGIN_ROTS));
    // ****************************************************************
    // Factory default state.
    // ****************************************************************
    localparam logic signed [31:0] ACT_DEF = 32'sh0000c800;
    localparam logic signed [31:0] MEND_DEF = ENC_RANGE;
    localparam logic signed [31:0] ULIM_DEF = MEND_DEF - MARGIN_CNT;
    localparam logic signed [31:0] LLIM_DEF = MEND_DEF - LOW_OFS;
    localparam logic [15:0] SCALE_DEF = 16'h0190;
    localparam logic signed [31:0] REF_DEF = 32'sh00000000;
    localparam logic signed [31:0] LOOP_DEF = 32'shffffff06;
    localparam logic signed [31:0] WIN_DEF = 32'sh0000000a;
    localparam logic signed [31:0] DRAG_DEF = 32'sh00000190;
    // ****************************************************************
    // Register word indices; the byte address is four times the index.
    // ****************************************************************
    localparam logic [9:0] IDX_TGT = 10'h004;
    localparam logic [9:0] IDX_ACT = 10'h00a;
    localparam logic [9:0] IDX_DIR = 10'h01a;
    localparam logic [9:0] IDX_NUM = 10'h01c;
    localparam logic [9:0] IDX_DEN = 10'h01e;
    localparam logic [9:0] IDX_REF = 10'h020;
    localparam logic [9:0] IDX_MEND = 10'h022;
    localparam logic [9:0] IDX_ULIM = 10'h024;
    localparam logic [9:0] IDX_LLIM = 10'h026;
    localparam logic [9:0] IDX_WIN = 10'h028;
    localparam logic [9:0] IDX_LOOP = 10'h02a;
    localparam logic [9:0] IDX_DRAG = 10'h02c;
    localparam logic [9:0] IDX_SAVE = 10'h071;
    localparam logic [9:0] IDX_STAT = 10'h080;
    localparam logic [9:0] IDX_MASK = 10'h081;
    localparam logic [9:0] IDX_ECHO = 10'h082;
    localparam logic [9:0] IDX_ECHOV = 10'h083;
    localparam logic [9:0] IDX_SPR = 10'h084;
    // ****************************************************************
    // Status bits.
    // ****************************************************************
    localparam int ST_TGT = 0;
    localparam int ST_MEND = 1;
    localparam int ST_SAVE = 2;
    localparam int ST_W = 3;

    typedef struct packed {
        logic start;
        logic signed [31:0] act;
        logic signed [31:0] target;
        logic signed [31:0] loop_len;
        logic signed [31:0] window;
        logic signed [31:0] drag;
    } prm_mot_cmd_t;
endpackage
`default_nettype wire

// ==== prm_map.sv ====
// Position range mapping: parameter store, scaling and range checks behind APB.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Encoder spans 256 rotations; positioning only within 250, 3 kept at each end.
// - Factory state: actual 51200, upper limit 101200, lower limit 1200.
// - Upper mapping end defaults to 102400, that is 256 rotations.
// - New mapping end accepted only 3 to 253 rotations above actual position.
// - Mapping end write sets limits to end minus 3 and minus 253 rotations.
// - Numerator and denominator default to 400, referencing value to 0.
// - Direction write restores reference, mapping end and both limits to defaults.
// - Scaling change recalculates every position, limit, window, loop and drag value.
// - Reference change recalculates target, actual, mapping end and both limits.
// - Reference is an offset on target, actual, mapping end and both limits.
// - Writing the actual value sets reference to the difference, effective at once.
// - Runs reaching into the end margins are refused as a bad target.
// - Position state survives loss of the motor supply.
// - A successful write echoes the value a read of that parameter returns.
// - Steps per rotation equal 400 times denominator over numerator.
module prm_map
    import prm_pkg::*;
#(
    parameter int ENC_W = 17
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic IRQ,
    input wire logic [ENC_W-1:0] ENC_POS,
    output logic NV_SAVE_REQ,
    input wire logic NV_SAVE_DONE,
    output prm_mot_cmd_t MOT_CMD
);
    logic [ENC_W-1:0] enc_s1_ff, enc_s2_ff, enc_s3_ff, enc_ff;
    logic dir_ff;
    logic [15:0] num_ff, den_ff;
    logic signed [31:0] refb_ff, mend_ff, ulim_ff, llim_ff;
    prm_mot_cmd_t mot_ff;
    logic busy_ff, pready_ff, err_ff, echo_pend_ff;
    logic [31:0] prdata_ff, echo_val_ff;
    logic [ST_W-1:0] stat_ff, mask_ff, ev, clr;
    logic [9:0] echo_idx_ff, idx;
    logic signed [31:0] pe, act_b, wdata_s, wb, act_usr;
    logic acc, commit, wr_ok, nxt_err;

    // ****************************************************************
    // Arithmetic.
    // ****************************************************************
    // Values are kept in base counts, so any scaling change shows at once in every read except the echo value.
    function automatic logic signed [31:0] scl(input logic signed [31:0] v,
                                               input logic [15:0] m, input logic [15:0] d);
        logic signed [63:0] t;
        t = (64'(v) * 64'($signed({1'b0, m}))) / 64'($signed({1'b0, d}));
        return t[31:0];
    endfunction

    function automatic logic signed [31:0] wrap(input logic signed [31:0] v);
        logic signed [31:0] m;
        m = v % ENC_RANGE;
        return (m < 0) ? m + ENC_RANGE : m;
    endfunction

    function automatic logic signed [31:0] to_usr(input logic signed [31:0] b);
        return scl(b + refb_ff, den_ff, num_ff);
    endfunction

    function automatic logic signed [31:0] from_usr(input logic signed [31:0] u);
        return scl(u, num_ff, den_ff) - refb_ff;
    endfunction

    function automatic logic is_map(input logic [9:0] i);
        return i inside {IDX_TGT, IDX_ACT, IDX_DIR, IDX_NUM, IDX_DEN, IDX_REF, IDX_MEND,
                         IDX_ULIM, IDX_LLIM, IDX_WIN, IDX_LOOP, IDX_DRAG, IDX_SAVE,
                         IDX_STAT, IDX_MASK, IDX_ECHO, IDX_ECHOV, IDX_SPR};
    endfunction

    function automatic logic [31:0] rdval(input logic [9:0] i);
        if (i == IDX_TGT) return to_usr(mot_ff.target);
        else if (i == IDX_ACT) return to_usr(act_b);
        else if (i == IDX_DIR) return {31'h0, dir_ff};
        else if (i == IDX_NUM) return {16'h0, num_ff};
        else if (i == IDX_DEN) return {16'h0, den_ff};
        else if (i == IDX_REF) return scl(refb_ff, den_ff, num_ff);
        else if (i == IDX_MEND) return to_usr(mend_ff);
        else if (i == IDX_ULIM) return to_usr(ulim_ff);
        else if (i == IDX_LLIM) return to_usr(llim_ff);
        else if (i == IDX_WIN) return scl(mot_ff.window, den_ff, num_ff);
        else if (i == IDX_LOOP) return scl(mot_ff.loop_len, den_ff, num_ff);
        else if (i == IDX_DRAG) return scl(mot_ff.drag, den_ff, num_ff);
        else if (i == IDX_SAVE) return {31'h0, busy_ff};
        else if (i == IDX_STAT) return 32'(stat_ff);
        else if (i == IDX_MASK) return 32'(mask_ff);
        else if (i == IDX_ECHO) return 32'(echo_idx_ff);
        else if (i == IDX_ECHOV) return echo_val_ff;
        else if (i == IDX_SPR) return scl(32'(ROT_CNT), den_ff, num_ff);
        else return 32'h0;
    endfunction

    // ****************************************************************
    // Encoder input.
    // ****************************************************************
    // Only the bus reset presets this to ACT_DEF; motor supply state has no path in.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            enc_s1_ff <= ENC_W'(ACT_DEF);
            enc_s2_ff <= ENC_W'(ACT_DEF);
            enc_s3_ff <= ENC_W'(ACT_DEF);
            enc_ff <= ENC_W'(ACT_DEF);
        end else begin
            enc_s1_ff <= ENC_POS;
            enc_s2_ff <= enc_s1_ff;
            enc_s3_ff <= enc_s2_ff;
            if (enc_s2_ff == enc_s3_ff) begin
                enc_ff <= enc_s3_ff;
            end
        end
    end

    // The wrap point of the encoder is placed by the mapping end.
    always_comb begin
        pe = 32'(enc_ff);
        if (dir_ff && enc_ff != '0) begin
            pe = ENC_RANGE - 32'(enc_ff);
        end
        act_b = mend_ff - wrap(mend_ff - pe);
        act_usr = to_usr(act_b);
    end

    // ****************************************************************
    // Bus slave.
    // ****************************************************************
    assign idx = PADDR[11:2];
    assign wdata_s = $signed(PWDATA);
    assign acc = PSEL && PENABLE;
    assign commit = acc && pready_ff;
    assign wr_ok = commit && PWRITE && !err_ff;

    // The converters read the scaling state, so they live in processes that follow it.
    always_comb begin
        wb = from_usr(wdata_s);
        nxt_err = 1'b0;
        if (!is_map(idx)) begin
            nxt_err = 1'b1;
        end else if (PWRITE) begin
            if (idx == IDX_ECHO || idx == IDX_ECHOV || idx == IDX_SPR) begin
                nxt_err = 1'b1;
            end else if ((idx == IDX_NUM || idx == IDX_DEN)
                         && (PWDATA[15:0] == 16'h0 || PWDATA[31:16] != 16'h0)) begin
                nxt_err = 1'b1;
            end else if (idx == IDX_MEND
                         && (wb < act_b + MARGIN_CNT || wb > act_b + LOW_OFS)) begin
                nxt_err = 1'b1;
            end else if (idx == IDX_TGT
                         && (wb < llim_ff || wb > ulim_ff
                             || wb + mot_ff.loop_len < mend_ff - LOW_OFS
                             || wb + mot_ff.loop_len > mend_ff - MARGIN_CNT)) begin
                nxt_err = 1'b1;
            end else if (idx == IDX_SAVE && PWDATA > 32'h1) begin
                nxt_err = 1'b1;
            end
        end
    end

    // One wait state gives time to register read data and the verdict.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            pready_ff <= 1'b0;
            err_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else begin
            pready_ff <= acc && !pready_ff;
            if (acc && !pready_ff) begin
                err_ff <= nxt_err;
                prdata_ff <= (PWRITE || nxt_err) ? 32'h0 : rdval(idx);
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            echo_pend_ff <= 1'b0;
            echo_idx_ff <= 10'h000;
            echo_val_ff <= 32'h0;
        end else begin
            echo_pend_ff <= wr_ok;
            if (wr_ok) begin
                echo_idx_ff <= idx;
            end
            if (echo_pend_ff) begin
                echo_val_ff <= rdval(echo_idx_ff);
            end
        end
    end

    // ****************************************************************
    // Parameters.
    // ****************************************************************
    always_ff @(posedge CLK) begin
        if (SRST) begin
            dir_ff <= 1'b0;
            num_ff <= SCALE_DEF;
            den_ff <= SCALE_DEF;
        end else if (wr_ok) begin
            if (idx == IDX_DIR) begin
                dir_ff <= PWDATA[0];
            end else if (idx == IDX_NUM) begin
                num_ff <= PWDATA[15:0];
            end else if (idx == IDX_DEN) begin
                den_ff <= PWDATA[15:0];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            refb_ff <= REF_DEF;
        end else if (wr_ok) begin
            if (idx == IDX_DIR) begin
                refb_ff <= REF_DEF;
            end else if (idx == IDX_REF) begin
                refb_ff <= scl(wdata_s, num_ff, den_ff);
            end else if (idx == IDX_ACT) begin
                refb_ff <= scl(wdata_s, num_ff, den_ff) - act_b;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            mend_ff <= MEND_DEF;
            ulim_ff <= ULIM_DEF;
            llim_ff <= LLIM_DEF;
        end else if (wr_ok) begin
            if (idx == IDX_DIR) begin
                mend_ff <= MEND_DEF;
                ulim_ff <= ULIM_DEF;
                llim_ff <= LLIM_DEF;
            end else if (idx == IDX_MEND) begin
                mend_ff <= wb;
                ulim_ff <= wb - MARGIN_CNT;
                llim_ff <= wb - LOW_OFS;
            end else if (idx == IDX_ULIM) begin
                ulim_ff <= wb;
            end else if (idx == IDX_LLIM) begin
                llim_ff <= wb;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            mot_ff <= '{1'b0, ACT_DEF, ACT_DEF, LOOP_DEF, WIN_DEF, DRAG_DEF};
        end else begin
            mot_ff.start <= wr_ok && idx == IDX_TGT;
            mot_ff.act <= act_b;
            if (wr_ok) begin
                if (idx == IDX_TGT) begin
                    mot_ff.target <= wb;
                end else if (idx == IDX_WIN) begin
                    mot_ff.window <= scl(wdata_s, num_ff, den_ff);
                end else if (idx == IDX_LOOP) begin
                    mot_ff.loop_len <= scl(wdata_s, num_ff, den_ff);
                end else if (idx == IDX_DRAG) begin
                    mot_ff.drag <= scl(wdata_s, num_ff, den_ff);
                end
            end
        end
    end

    // ****************************************************************
    // Save and interrupts.
    // ****************************************************************
    always_ff @(posedge CLK) begin
        if (SRST) begin
            busy_ff <= 1'b0;
        end else if (wr_ok && idx == IDX_SAVE && PWDATA[0]) begin
            busy_ff <= 1'b1;
        end else if (NV_SAVE_DONE) begin
            busy_ff <= 1'b0;
        end
    end

    always_comb begin
        ev = '0;
        ev[ST_TGT] = commit && PWRITE && err_ff && idx == IDX_TGT;
        ev[ST_MEND] = commit && PWRITE && err_ff && idx == IDX_MEND;
        ev[ST_SAVE] = busy_ff && NV_SAVE_DONE;
        clr = (wr_ok && idx == IDX_STAT) ? PWDATA[ST_W-1:0] : '0;
    end

    // A new event wins over a clear that lands in the same cycle.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            stat_ff <= '0;
            mask_ff <= '0;
        end else begin
            stat_ff <= (stat_ff & ~clr) | ev;
            if (wr_ok && idx == IDX_MASK) begin
                mask_ff <= PWDATA[ST_W-1:0];
            end
        end
    end

    assign PRDATA = prdata_ff;
    assign PREADY = pready_ff;
    assign PSLVERR = pready_ff && err_ff;
    assign IRQ = |(stat_ff & mask_ff);
    assign NV_SAVE_REQ = busy_ff;
    assign MOT_CMD = mot_ff;

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    property p_reset_defaults;
        @(posedge CLK) disable iff (SRST)
        $fell(SRST) |-> mend_ff == MEND_DEF && ulim_ff == ULIM_DEF && llim_ff == LLIM_DEF
            && num_ff == SCALE_DEF && den_ff == SCALE_DEF && refb_ff == REF_DEF;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("bad defaults");
    property p_mend_window;
        @(posedge CLK) disable iff (SRST)
        wr_ok && idx == IDX_MEND |-> $past(wb) >= $past(act_b) + MARGIN_CNT
            && $past(wb) <= $past(act_b) + LOW_OFS;
    endproperty
    a_mend_window: assert property (p_mend_window) else $error("end outside window");
    property p_mend_refused;
        @(posedge CLK) disable iff (SRST)
        commit && PWRITE && err_ff && idx == IDX_MEND |=> $stable(mend_ff)
            && $stable(ulim_ff) && $stable(llim_ff) && stat_ff[ST_MEND];
    endproperty
    a_mend_refused: assert property (p_mend_refused) else $error("refused end moved");
    property p_mend_limits;
        @(posedge CLK) disable iff (SRST)
        wr_ok && idx == IDX_MEND |=> mend_ff == $past(wb) && ulim_ff == mend_ff - MARGIN_CNT
            && llim_ff == mend_ff - LOW_OFS;
    endproperty
    a_mend_limits: assert property (p_mend_limits) else $error("limits not derived");
    property p_dir_restore;
        @(posedge CLK) disable iff (SRST)
        wr_ok && idx == IDX_DIR |=> refb_ff == REF_DEF && mend_ff == MEND_DEF
            && ulim_ff == ULIM_DEF && llim_ff == LLIM_DEF;
    endproperty
    a_dir_restore: assert property (p_dir_restore) else $error("direction no restore");
    property p_scale_base;
        @(posedge CLK) disable iff (SRST)
        wr_ok && (idx == IDX_NUM || idx == IDX_DEN) |=> $stable(mend_ff) && $stable(refb_ff)
            && $stable(mot_ff.target) && $stable(mot_ff.loop_len);
    endproperty
    a_scale_base: assert property (p_scale_base) else $error("base value moved");
    property p_act_write;
        @(posedge CLK) disable iff (SRST)
        wr_ok && idx == IDX_ACT && num_ff == den_ff |=> !$stable(act_b)
            || act_usr == $past(wdata_s);
    endproperty
    a_act_write: assert property (p_act_write) else $error("actual not taken");
    property p_save_seq;
        @(posedge CLK) disable iff (SRST)
        (wr_ok && idx == IDX_SAVE && PWDATA[0] |=> NV_SAVE_REQ)
            and (NV_SAVE_REQ && NV_SAVE_DONE && !wr_ok |=> !NV_SAVE_REQ);
    endproperty
    a_save_seq: assert property (p_save_seq) else $error("save sequence wrong");
    property p_tgt_range;
        @(posedge CLK) disable iff (SRST)
        mot_ff.start |-> mot_ff.target >= llim_ff && mot_ff.target <= ulim_ff
            && mot_ff.target + mot_ff.loop_len >= mend_ff - LOW_OFS
            && mot_ff.target + mot_ff.loop_len <= mend_ff - MARGIN_CNT;
    endproperty
    a_tgt_range: assert property (p_tgt_range) else $error("target in margin");
    property p_echo;
        @(posedge CLK) disable iff (SRST)
        wr_ok |=> ##1 echo_idx_ff == $past(idx, 2);
    endproperty
    a_echo: assert property (p_echo) else $error("echo index wrong");
endmodule // prm_map
`default_nettype wire

// ==== prm_nv_model.sv ====
// Behavioural nonvolatile store controller answering save requests.
`timescale 1ns/10ps
`default_nettype none
module prm_nv_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] dly,
    input wire logic save_req,
    output logic save_done
);
    // ****************
    // Store timing.
    // ****************
    logic [7:0] cnt_ff;
    // The counter saturates, so a request left high is answered only once, except with dly at 8'hff, where done stays high.
    always_ff @(posedge clk) begin
        if (srst || !save_req) begin
            cnt_ff <= 8'h00;
        end else if (cnt_ff != 8'hff) begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end
    assign save_done = save_req && (cnt_ff == dly);
endmodule // prm_nv_model
`default_nettype wire

// ==== prm_tb.sv ====
// Self-checking testbench for the position range mapping block.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import prm_pkg::*;
    // ****************
    // Bench.
    // ****************
    logic clk, srst, psel, penable, pwrite, prdy, perr, irq, nv_req, nv_done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [16:0] enc;
    logic [7:0] dly;
    prm_mot_cmd_t cmd;
    int num_errors = 0;
    int checked = 0;
    prm_map i_dut (.CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(prdy), .PSLVERR(perr),
        .IRQ(irq), .ENC_POS(enc), .NV_SAVE_REQ(nv_req), .NV_SAVE_DONE(nv_done), .MOT_CMD(cmd));
    prm_nv_model i_nv (.clk(clk), .srst(srst), .dly(dly), .save_req(nv_req),
        .save_done(nv_done));
    task automatic tally_and_finish();
        $display("Compared %0d, mismatched %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    // One APB transfer; the answer is waited for, never assumed.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'b1 && n < 16);
        if (prdy !== 1'b1) begin
            num_errors++;
            $display("FAIL %0t no bus answer", $time);
            tally_and_finish();
        end
        q = prdata;
        e = perr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wrc(input logic [9:0] i, input logic [31:0] d, input logic ee);
        logic [31:0] q;
        logic e;
        xfer(1'b1, {i, 2'b00}, d, q, e);
        chk1(e, ee);
    endtask
    task automatic rdc(input logic [9:0] i, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        xfer(1'b0, {i, 2'b00}, 32'h0, q, e);
        chk(q, exp);
    endtask
    task automatic s_defaults();
        rdc(IDX_ACT, 32'h0000c800);
        rdc(IDX_ULIM, 32'h00018b50);
        rdc(IDX_LLIM, 32'h000004b0);
        rdc(IDX_MEND, 32'h00019000);
        rdc(IDX_NUM, 32'h00000190);
        rdc(IDX_DEN, 32'h00000190);
        rdc(IDX_REF, 32'h00000000);
        rdc(IDX_SPR, 32'h00000190);
    endtask
    task automatic s_mend();
        wrc(IDX_MASK, 32'h00000002, 1'b0);
        wrc(IDX_MEND, 32'h0000ccaf, 1'b1);
        rdc(IDX_MEND, 32'h00019000);
        rdc(IDX_ULIM, 32'h00018b50);
        rdc(IDX_STAT, 32'h00000002);
        chk1(irq, 1'b1);
        wrc(IDX_STAT, 32'h00000002, 1'b0);
        @(posedge clk);
        chk1(irq, 1'b0);
        wrc(IDX_MEND, 32'h0000ccb0, 1'b0);
        rdc(IDX_ULIM, 32'h0000c800);
        rdc(IDX_LLIM, 32'hffff4160);
        wrc(IDX_MEND, 32'h00025351, 1'b1);
        wrc(IDX_MEND, 32'h00025350, 1'b0);
        rdc(IDX_ULIM, 32'h00024ea0);
        rdc(IDX_LLIM, 32'h0000c800);
    endtask
    // The first target is inside the limits but its loop run dips into the margin.
    task automatic s_target();
        wrc(IDX_STAT, 32'h00000007, 1'b0);
        wrc(IDX_TGT, 32'h0000c800, 1'b1);
        wrc(IDX_TGT, 32'h00024ea1, 1'b1);
        chk1(irq, 1'b0);
        wrc(IDX_TGT, 32'h0000c990, 1'b0);
        @(posedge clk);
        chk1(cmd.start, 1'b1);
        chk(cmd.target, 32'h0000c990);
    endtask
    task automatic s_dir_ref();
        wrc(IDX_REF, 32'h000003e8, 1'b0);
        wrc(IDX_DIR, 32'h00000001, 1'b0);
        rdc(IDX_REF, 32'h00000000);
        rdc(IDX_MEND, 32'h00019000);
        rdc(IDX_ULIM, 32'h00018b50);
        rdc(IDX_LLIM, 32'h000004b0);
        wrc(IDX_REF, 32'h000003e8, 1'b0);
        rdc(IDX_ACT, 32'h0000cbe8);
        rdc(IDX_TGT, 32'h0000cd78);
        rdc(IDX_MEND, 32'h000193e8);
        rdc(IDX_ULIM, 32'h00018f38);
        rdc(IDX_LLIM, 32'h00000898);
        wrc(IDX_ACT, 32'h00000000, 1'b0);
        rdc(IDX_REF, 32'hffff3800);
        rdc(IDX_ACT, 32'h00000000);
        wrc(IDX_REF, 32'h00000000, 1'b0);
    endtask
    task automatic s_scale();
        wrc(IDX_DEN, 32'h00000320, 1'b0);
        rdc(IDX_SPR, 32'h00000320);
        rdc(IDX_ACT, 32'h00019000);
        rdc(IDX_TGT, 32'h00019320);
        rdc(IDX_MEND, 32'h00032000);
        rdc(IDX_WIN, 32'h00000014);
        rdc(IDX_DRAG, 32'h00000320);
        rdc(IDX_LOOP, 32'hfffffe0c);
        wrc(IDX_NUM, 32'h00000000, 1'b1);
        wrc(IDX_DEN, 32'h00000190, 1'b0);
    endtask
    // A prompt store may finish before a read can see the pending value.
    task automatic s_save(input logic [7:0] d);
        logic [31:0] q;
        logic e;
        int n;
        dly <= d;
        wrc(IDX_SAVE, 32'h00000001, 1'b0);
        if (d > 8'h08) begin
            rdc(IDX_SAVE, 32'h00000001);
        end
        n = 0;
        do begin
            xfer(1'b0, {IDX_SAVE, 2'b00}, 32'h0, q, e);
            n++;
        end while (q !== 32'h0 && n < 50);
        chk(q, 32'h00000000);
        if (n >= 50) begin
            tally_and_finish();
        end
        chk1(nv_req, 1'b0);
        rdc(IDX_STAT, 32'h00000005);
        wrc(IDX_SAVE, 32'h00000002, 1'b1);
    endtask
    // Start-up writes in the advised order; range values are zero-based plus the reference.
    task automatic s_order();
        logic [31:0] q;
        logic e;
        wrc(IDX_DIR, 32'h00000000, 1'b0);
        wrc(IDX_NUM, 32'h00000190, 1'b0);
        wrc(IDX_DEN, 32'h00000190, 1'b0);
        wrc(IDX_REF, 32'h00000064, 1'b0);
        xfer(1'b0, {IDX_REF, 2'b00}, 32'h0, q, e);
        chk(q, 32'h00000064);
        wrc(IDX_MEND, 32'h00019000 + q, 1'b0);
        wrc(IDX_ULIM, 32'h00017700 + q, 1'b0);
        wrc(IDX_LLIM, 32'h00001388 + q, 1'b0);
        wrc(IDX_WIN, 32'h00000008, 1'b0);
        wrc(IDX_LOOP, 32'h00000032, 1'b0);
        wrc(IDX_DRAG, 32'h000000c8, 1'b0);
        rdc(IDX_MEND, 32'h00019064);
        rdc(IDX_ULIM, 32'h00017764);
        rdc(IDX_LLIM, 32'h000013ec);
        chk(cmd.loop_len, 32'h00000032);
        chk(cmd.window, 32'h00000008);
        chk(cmd.drag, 32'h000000c8);
        chk(cmd.act, 32'h0000c800);
    endtask
    task automatic s_echo();
        logic [31:0] q;
        logic e;
        wrc(IDX_WIN, 32'h00000005, 1'b0);
        rdc(IDX_ECHO, 32'(IDX_WIN));
        rdc(IDX_ECHOV, 32'h00000005);
        rdc(IDX_WIN, 32'h00000005);
        wrc(IDX_ECHO, 32'h00000000, 1'b1);
        xfer(1'b0, 12'h3fc, 32'h0, q, e);
        chk1(e, 1'b1);
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        enc = 17'h0c800;
        dly = 8'h01;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        repeat (6) @(posedge clk);
        s_defaults();
        s_mend();
        s_target();
        s_dir_ref();
        s_scale();
        s_save(8'h01);
        s_save(8'h28);
        s_echo();
        s_order();
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
